// >>> src/qdu_ctrl.sv
// Per-group update mode control for eight quad converters behind APB
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each group has instant, manual-load or timed mode in its control register
// - after reset every group is in instant mode
// - instant mode sends written data promptly and updates output when sent
// - one serial link per group; channels serial, groups concurrent
// - one channel transfer takes 1.4us
// - status read adds 3.4us per update cycle
// - instant mode offers no simultaneous update
// - manual mode sends data but does not update outputs
// - setting load bit registers pending group update in manual mode
// - standalone load waits for group data, then updates all four outputs
// - global load waits for all global groups, then updates them together
// - load bit clears itself once outputs are updated
// - busy stays set while data pending, sending, or load outstanding
// - sequencer starts on start bit; same write starts groups together
// - sequencer sets data request flag; software clears it
// - per-group underflow flag readable in global status
// - enabled sequencer interrupt status set on data request; software clears
// - last written channel value kept for later sequence steps
// - clearing start bit stops sequencer on the next clock; busy clears once no data is pending or sending
// - data writes accepted during a transfer and queued
// - interrupt output when master enable and any status bit set
// - interrupt status sets only if enabled before the event
module qdu_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [7:0] dac_sclk,
  output logic [7:0] dac_sync_n,
  output logic [31:0] dac_sdo,
  output logic [7:0] dac_ldac_n
);
  localparam int NG = qdu_pkg::NGRP;

  logic [31:0] prdata_q, rd_mux;
  logic pready_q, pslverr_q, irq_q, mie_q;
  logic [NG-1:0] run_q, load_q, dreq_q, ufl_q, ist_q;
  logic [NG-1:0] busy_w, idle_w, is_inst, is_man, is_glob, is_tim, sie_v, seq_v;
  logic [NG-1:0] expire, upd, ser_busy, ser_done, lstat_v, ld_set, gl_grp;
  logic [NG-1:0] dreq_clr, ufl_clr, ist_clr;
  logic [31:0] ctl_rd [NG];
  logic [23:0] tmr_rd [NG];
  logic [15:0] rda [NG];
  logic acc, wr_en, mapped, gl_ready, gl_req;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // Bus commit point and address map check
  assign acc = psel & penable & pready_q;
  assign wr_en = acc & pwrite & mapped; // Refused addresses write nothing
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr < qdu_pkg::OFS_END) || paddr[7]);

  // APB answer: one wait state, registered read data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= (pwrite || !mapped) ? 32'h00000000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    if (paddr[7]) begin
      rd_mux = {16'h0000, rda[paddr[6:4]]};
    end else begin
      unique case (paddr)
        qdu_pkg::OFS_GCTRL: begin
          rd_mux[qdu_pkg::GCTRL_MIE] = mie_q;
          rd_mux[qdu_pkg::GCTRL_RUN +: NG] = run_q;
        end
        qdu_pkg::OFS_GSTAT: begin
          rd_mux[qdu_pkg::GSTAT_BUSY +: NG] = busy_w;
          rd_mux[qdu_pkg::GSTAT_DREQ +: NG] = dreq_q;
          rd_mux[qdu_pkg::GSTAT_UFL +: NG] = ufl_q;
        end
        qdu_pkg::OFS_LOAD: rd_mux[NG-1:0] = load_q;
        qdu_pkg::OFS_ISTAT: rd_mux[NG-1:0] = ist_q;
        default: begin
          for (int g = 0; g < NG; g++) begin
            if (paddr == qdu_pkg::OFS_CTL0 + 8'(4 * g)) begin
              rd_mux = ctl_rd[g];
            end
            if (paddr == qdu_pkg::OFS_TMR0 + 8'(4 * g)) begin
              rd_mux = {8'h00, tmr_rd[g]};
            end
          end
        end
      endcase
    end
  end

  // Write strobes for set and clear fields
  assign ld_set = (wr_en && paddr == qdu_pkg::OFS_LOAD) ? pwdata[NG-1:0] : '0;
  assign dreq_clr = (wr_en && paddr == qdu_pkg::OFS_GSTAT) ? pwdata[qdu_pkg::GSTAT_DREQ +: NG] : '0;
  assign ufl_clr = (wr_en && paddr == qdu_pkg::OFS_GSTAT) ? pwdata[qdu_pkg::GSTAT_UFL +: NG] : '0;
  assign ist_clr = (wr_en && paddr == qdu_pkg::OFS_ISTAT) ? pwdata[NG-1:0] : '0;

  // Global control: master interrupt enable and sequencer run bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mie_q <= 1'b0;
      run_q <= '0;
    end else if (wr_en && paddr == qdu_pkg::OFS_GCTRL) begin
      mie_q <= pwdata[qdu_pkg::GCTRL_MIE];
      run_q <= pwdata[qdu_pkg::GCTRL_RUN +: NG];
    end
  end

  // Load requests: set by software, cleared by the manual-mode update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q <= '0;
    end else begin
      load_q <= ld_set | (load_q & ~(upd & is_man));
    end
  end

  // Sequencer data request, underflow and interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_q <= '0;
      ufl_q <= '0;
      ist_q <= '0;
    end else begin
      dreq_q <= expire | (dreq_q & ~dreq_clr);
      ufl_q <= (expire & dreq_q) | (ufl_q & ~ufl_clr);
      ist_q <= (expire & sie_v) | (ist_q & ~ist_clr);
    end
  end

  // Interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= mie_q & (|ist_q);
    end
  end

  // Global load: all global groups idle and any of them requested
  assign gl_grp = is_man & is_glob;
  assign gl_ready = &(~gl_grp | idle_w);
  assign gl_req = |(gl_grp & load_q);

  for (genvar g = 0; g < NG; g++) begin : grp
    logic [2:0] mode_q;
    logic glob_q, sie_q, sten_q, ctl_wr, tmr_wr;
    logic [23:0] tmr_q, cnt_q, frame;
    logic [3:0] pend_q, wr_set, clr;
    logic [1:0] pick, lch_q;
    logic [15:0] rdb;
    logic [5:0] len;
    logic found, can_go, launch_q, lstat_q, stat_due_q, seq_q, ldac_n_q;

    assign ctl_wr = wr_en && (paddr == qdu_pkg::OFS_CTL0 + 8'(4 * g));
    assign tmr_wr = wr_en && (paddr == qdu_pkg::OFS_TMR0 + 8'(4 * g));

    // Group mode and options; illegal mode codes keep the old mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_q <= qdu_pkg::MODE_INSTANT;
        glob_q <= 1'b0;
        sie_q <= 1'b0;
        sten_q <= 1'b0;
      end else if (ctl_wr) begin
        if (pwdata[qdu_pkg::CTL_MODE +: 3] inside {qdu_pkg::MODE_INSTANT, qdu_pkg::MODE_MANUAL,
                                                   qdu_pkg::MODE_TIMED}) begin
          mode_q <= pwdata[qdu_pkg::CTL_MODE +: 3];
        end
        glob_q <= pwdata[qdu_pkg::CTL_GLOB];
        sie_q <= pwdata[qdu_pkg::CTL_SIE];
        sten_q <= pwdata[qdu_pkg::CTL_STEN];
      end
    end

    // Sequence period
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tmr_q <= qdu_pkg::TMR_RST;
      end else if (tmr_wr) begin
        tmr_q <= pwdata[23:0];
      end
    end

    // Pending channels: a new write wins over the launch clear
    assign wr_set = (wr_en && paddr[7] && paddr[6:4] == 3'(g)) ? (4'h1 << paddr[3:2]) : 4'h0;
    assign can_go = !ser_busy[g] && !launch_q;
    assign clr = (can_go && found) ? (4'h1 << pick) : 4'h0;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_q <= 4'h0;
      end else begin
        pend_q <= wr_set | (pend_q & ~clr);
      end
    end

    // Lowest pending channel goes first
    always_comb begin
      pick = 2'h0;
      found = 1'b0;
      for (int c = 3; c >= 0; c--) begin
        if (pend_q[c]) begin
          pick = 2'(c);
          found = 1'b1;
        end
      end
    end

    // Launch a data frame, or a status frame when no data waits
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        launch_q <= 1'b0;
        lstat_q <= 1'b0;
        lch_q <= 2'h0;
      end else begin
        launch_q <= can_go && (found || stat_due_q);
        if (can_go) begin
          lstat_q <= !found;
          lch_q <= pick;
        end
      end
    end

    // Status read owed after each data cycle when enabled
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stat_due_q <= 1'b0;
      end else begin
        stat_due_q <= (ser_done[g] && !lstat_q && sten_q) || (stat_due_q && !(can_go && !found));
      end
    end

    // Sequencer run state and period counter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        seq_q <= 1'b0;
        cnt_q <= 24'h000000;
      end else begin
        seq_q <= run_q[g] && (mode_q == qdu_pkg::MODE_TIMED);
        if (!seq_q || cnt_q == 24'h000000) begin
          cnt_q <= tmr_q;
        end else begin
          cnt_q <= cnt_q - 24'h000001;
        end
      end
    end
    assign expire[g] = seq_q && (cnt_q == 24'h000000);

    // Output update events per mode
    assign upd[g] = (is_inst[g] && ser_done[g] && !lstat_q)
                  || (is_man[g] && !glob_q && load_q[g] && idle_w[g])
                  || (gl_grp[g] && gl_ready && gl_req)
                  || expire[g];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ldac_n_q <= 1'b1;
      end else begin
        ldac_n_q <= !upd[g];
      end
    end
    assign dac_ldac_n[g] = ldac_n_q;

    // Frame: command byte with channel, then sixteen data bits
    assign frame = lstat_q ? {qdu_pkg::CMD_STAT, 16'h0000} : {qdu_pkg::CMD_WRITE, lch_q, rdb};
    assign len = lstat_q ? qdu_pkg::STAT_LEN : qdu_pkg::XFER_LEN;

    qdu_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(|wr_set),
      .waddr(paddr[3:2]),
      .wdata(pwdata[15:0]),
      .raddr_a(paddr[3:2]),
      .raddr_b(pick),
      .rdata_a_q(rda[g]),
      .rdata_b_q(rdb)
    );

    // Own serial link per group, so groups run concurrently
    qdu_ser u_ser (
      .pclk(pclk),
      .presetn(presetn),
      .start(launch_q),
      .len(len),
      .frame(frame),
      .busy(ser_busy[g]),
      .done_q(ser_done[g]),
      .sclk_q(dac_sclk[g]),
      .sync_n_q(dac_sync_n[g]),
      .sdo_q(dac_sdo[4*g +: 4])
    );

    // Exported group state
    assign is_inst[g] = (mode_q == qdu_pkg::MODE_INSTANT);
    assign is_man[g] = (mode_q == qdu_pkg::MODE_MANUAL);
    assign is_tim[g] = (mode_q == qdu_pkg::MODE_TIMED);
    assign is_glob[g] = glob_q;
    assign sie_v[g] = sie_q;
    assign seq_v[g] = seq_q;
    assign lstat_v[g] = lstat_q;
    assign idle_w[g] = !(|pend_q) && !launch_q && !ser_busy[g];
    assign busy_w[g] = !idle_w[g] || stat_due_q || (is_man[g] && load_q[g]) || seq_q;
    assign ctl_rd[g] = {26'h0000000, sten_q, sie_q, glob_q, mode_q};
    assign tmr_rd[g] = tmr_q;
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_MODE: assert property (!$past(presetn) |-> is_inst == '1)
    else $error("group not in instant mode after reset");
  AST_INSTANT_UPD: assert property (is_inst[0] && ser_done[0] && !lstat_v[0] |=> !dac_ldac_n[0])
    else $error("instant mode output not updated after transfer");
  AST_MANUAL_HOLD: assert property (is_man[1] && !is_glob[1] && !load_q[1] |=> dac_ldac_n[1])
    else $error("manual mode output updated without load");
  AST_LOAD_WAITS: assert property (is_man[1] && !is_glob[1] && load_q[1] && !idle_w[1] |=> dac_ldac_n[1])
    else $error("standalone load before data sent");
  AST_GLOBAL_SYNC: assert property (gl_grp[3:2] == 2'h3 |=> dac_ldac_n[2] == dac_ldac_n[3])
    else $error("global groups not updated together");
  AST_LOAD_CLEAR: assert property (is_man[1] && upd[1] && !ld_set[1] |=> !load_q[1])
    else $error("load bit not cleared after update");
  AST_BUSY_PEND: assert property (!idle_w[0] |-> busy_w[0])
    else $error("busy clear while transfer pending");
  AST_XFER_TIME: assert property ($rose(ser_busy[0]) && !lstat_v[0] |-> ##12 ser_done[0])
    else $error("channel transfer length wrong");
  AST_STAT_TIME: assert property ($rose(ser_busy[0]) && lstat_v[0] |-> ##32 ser_done[0])
    else $error("status slot length wrong");
  AST_START_TOGETHER: assert property (wr_en && paddr == qdu_pkg::OFS_GCTRL && pwdata[13:12] == 2'h3
      && is_tim[5:4] == 2'h3 |=> ##1 seq_v[5:4] == 2'h3)
    else $error("sequencers did not start together");
  AST_DREQ_SET: assert property (expire[4] |=> dreq_q[4] && !dac_ldac_n[4])
    else $error("expiry without data request and load");
  AST_UNDERFLOW: assert property (expire[4] && dreq_q[4] |=> ufl_q[4])
    else $error("underflow not flagged");
  AST_IRQ_ENABLE: assert property (!sie_v[5] && !ist_q[5] |=> !ist_q[5])
    else $error("interrupt status set while disabled");
  AST_IRQ_OUT: assert property (mie_q && $rose(ist_q[4]) |=> irq)
    else $error("interrupt output missing");
  AST_STOP: assert property (!run_q[4] |=> !seq_v[4])
    else $error("sequencer still running after stop");

  COV_INSTANT: cover property (is_inst[0] && !dac_ldac_n[0]);
  COV_GLOBAL: cover property (gl_grp[3:2] == 2'h3 && upd[2] && upd[3]);
  COV_UNDERFLOW: cover property (expire[4] && dreq_q[4]);
endmodule // qdu_ctrl
`default_nettype wire

// >>> include/qdu_pkg.sv
// Constants shared by the quad converter update controller
`default_nettype none
package qdu_pkg;
  localparam int NGRP = 8;
  localparam int CLK_NS = 100;
  localparam int XFER_NS = 1400;
  localparam int STAT_NS = 3400;
  localparam int XFER_CYC = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int STAT_CYC = (STAT_NS + CLK_NS - 1) / CLK_NS;
  // Serializer lengths leave out the pick and launch cycles
  localparam logic [5:0] XFER_LEN = 6'(XFER_CYC - 2);
  localparam logic [5:0] STAT_LEN = 6'(STAT_CYC - 2);
  localparam logic [5:0] SHIFT_CYC = 6'h0C;
  localparam logic [7:0] OFS_GCTRL = 8'h00;
  localparam logic [7:0] OFS_GSTAT = 8'h04;
  localparam logic [7:0] OFS_LOAD = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0C;
  localparam logic [7:0] OFS_CTL0 = 8'h10;
  localparam logic [7:0] OFS_TMR0 = 8'h30;
  localparam logic [7:0] OFS_END = 8'h50;
  localparam int GCTRL_MIE = 0;
  localparam int GCTRL_RUN = 8;
  localparam int GSTAT_BUSY = 0;
  localparam int GSTAT_DREQ = 8;
  localparam int GSTAT_UFL = 16;
  localparam int CTL_MODE = 0;
  localparam int CTL_GLOB = 3;
  localparam int CTL_SIE = 4;
  localparam int CTL_STEN = 5;
  localparam logic [2:0] MODE_INSTANT = 3'h1;
  localparam logic [2:0] MODE_MANUAL = 3'h2;
  localparam logic [2:0] MODE_TIMED = 3'h4;
  localparam logic [23:0] TMR_RST = 24'h0003E8;
  localparam logic [5:0] CMD_WRITE = 6'h00;
  localparam logic [7:0] CMD_STAT = 8'h80;
endpackage
`default_nettype wire

// >>> src/qdu_mem.sv
// Four-word channel data store with two registered read ports
`timescale 1ns/1ps
`default_nettype none
module qdu_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] raddr_a,
  input wire logic [1:0] raddr_b,
  output logic [15:0] rdata_a_q,
  output logic [15:0] rdata_b_q
);
  logic [15:0] mem_q [4];

  // Storage keeps the last value written per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered reads for bus and serializer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_a_q <= 16'h0000;
      rdata_b_q <= 16'h0000;
    end else begin
      rdata_a_q <= mem_q[raddr_a];
      rdata_b_q <= mem_q[raddr_b];
    end
  end
endmodule // qdu_mem
`default_nettype wire

// >>> src/qdu_ser.sv
// Nibble-wide serial frame sender for one quad converter
`timescale 1ns/1ps
`default_nettype none
module qdu_ser (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [5:0] len,
  input wire logic [23:0] frame,
  output logic busy,
  output logic done_q,
  output logic sclk_q,
  output logic sync_n_q,
  output logic [3:0] sdo_q
);
  typedef enum logic [1:0] {SER_IDLE = 2'h1, SER_SHIFT = 2'h2} qdu_ser_state_t;
  qdu_ser_state_t state_q;
  logic [5:0] cnt_q, len_q;
  logic [23:0] sh_q;

  assign busy = (state_q == SER_SHIFT);

  // Frame shifting: data changes on falling sclk, sampled on rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SER_IDLE;
      cnt_q <= 6'h00;
      len_q <= 6'h00;
      sh_q <= 24'h000000;
      done_q <= 1'b0;
      sclk_q <= 1'b0;
      sync_n_q <= 1'b1;
      sdo_q <= 4'h0;
    end else begin
      unique case (state_q)
        SER_IDLE: begin
          done_q <= 1'b0;
          if (start) begin
            state_q <= SER_SHIFT;
            cnt_q <= 6'h00;
            len_q <= len;
            sh_q <= {frame[19:0], 4'h0};
            sdo_q <= frame[23:20];
            sync_n_q <= 1'b0;
          end
        end
        SER_SHIFT: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q < qdu_pkg::SHIFT_CYC) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              sdo_q <= sh_q[23:20];
              sh_q <= {sh_q[19:0], 4'h0};
            end
          end
          if (cnt_q == qdu_pkg::SHIFT_CYC - 6'h01) begin
            sync_n_q <= 1'b1;
          end
          if (cnt_q == len_q - 6'h01) begin
            state_q <= SER_IDLE;
            done_q <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // qdu_ser
`default_nettype wire

// >>> tb/qdu_dac_model.sv
// Behavioural bank of eight quad converters fed by the serial links
`timescale 1ns/1ps
`default_nettype none
module qdu_dac_model (
  input wire logic pclk,
  input wire logic [7:0] dac_sclk,
  input wire logic [7:0] dac_sync_n,
  input wire logic [31:0] dac_sdo,
  input wire logic [7:0] dac_ldac_n,
  output logic [511:0] dac_out
);
  logic [23:0] sh [8];
  logic [15:0] inr [32];
  logic [7:0] sclk_p;
  logic [7:0] sync_p;
  // Power-up contents of inputs and outputs
  initial begin
    dac_out = '0;
    sclk_p = '0;
    sync_p = '1;
    for (int i = 0; i < 32; i++) begin
      inr[i] = 16'h0000;
    end
  end
  // Shift on rising serial clock, latch at frame end, update all four on strobe
  always @(posedge pclk) begin
    for (int g = 0; g < 8; g++) begin
      if (!dac_sync_n[g] && dac_sclk[g] && !sclk_p[g]) begin
        sh[g] = {sh[g][19:0], dac_sdo[4*g +: 4]};
      end
      if (dac_sync_n[g] && !sync_p[g] && sh[g][23:18] == 6'h00) begin
        inr[4*g + sh[g][17:16]] = sh[g][15:0];
      end
      if (!dac_ldac_n[g]) begin
        for (int k = 0; k < 4; k++) begin
          dac_out[(4*g+k)*16 +: 16] = inr[4*g+k];
        end
      end
    end
    sclk_p = dac_sclk;
    sync_p = dac_sync_n;
  end
endmodule // qdu_dac_model
`default_nettype wire

// >>> tb/quad_dac_update_mode_control_test.sv
// Self-checking bench of the update mode controller
`timescale 1ns/1ps
`default_nettype none
module quad_dac_update_mode_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, dac_sclk, dac_sync_n, dac_ldac_n;
  logic [31:0] pwdata, prdata, dac_sdo, rd, seed;
  logic [511:0] dac_out;
  logic [15:0] exp_val [32];
  int miscompares, num_checks, cycles;
  int chs [4] = '{0, 2, 2, 4};
  qdu_ctrl u_qdu_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .dac_sclk(dac_sclk), .dac_sync_n(dac_sync_n), .dac_sdo(dac_sdo), .dac_ldac_n(dac_ldac_n));
  qdu_dac_model u_qdu_dac_model (.pclk(pclk), .dac_sclk(dac_sclk), .dac_sync_n(dac_sync_n),
    .dac_sdo(dac_sdo), .dac_ldac_n(dac_ldac_n), .dac_out(dac_out));
  // Clock
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer with an idle cycle before it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll a register until the masked bits read clear
  task automatic wait_clr(input logic [7:0] a, input logic [31:0] m);
    for (int n = 0; n < 200; n++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === 32'h0) break;
    end
    // Let a pending output strobe reach the converter model
    repeat (2) @(posedge pclk);
  endtask
  task automatic put(input int ch);
    seed = xs(seed);
    exp_val[ch] = seed[15:0];
    apb(1'b1, 8'(8'h80 + 4*ch), {16'h0000, seed[15:0]});
  endtask
  function automatic logic [31:0] outv(input int ch);
    return {16'h0000, dac_out[ch*16 +: 16]};
  endfunction
  function automatic logic [7:0] ctl(input int g);
    return 8'(qdu_pkg::OFS_CTL0 + 4*g);
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'hD532C365;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and refused access
    for (int g = 0; g < 8; g++) begin
      apb(1'b0, ctl(g), 32'h0);
      chk(rd, {29'h0, qdu_pkg::MODE_INSTANT});
    end
    apb(1'b0, qdu_pkg::OFS_TMR0, 32'h0);
    chk(rd, {8'h00, qdu_pkg::TMR_RST});
    apb(1'b1, qdu_pkg::OFS_END, 32'hFFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h81, 32'h5A5A);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, qdu_pkg::OFS_CTL0, 32'h23);
    apb(1'b0, qdu_pkg::OFS_CTL0, 32'h0);
    chk(rd, 32'h21);
    $display("reset test done");
    // Instant mode, back-to-back writes, one rewritten while queued
    for (int i = 0; i < 4; i++) put(chs[i]);
    wait_clr(qdu_pkg::OFS_GSTAT, 32'h3);
    for (int i = 1; i < 4; i++) chk(outv(chs[i]), {16'h0, exp_val[chs[i]]});
    chk(outv(0), {16'h0, exp_val[0]});
    apb(1'b0, 8'h88, 32'h0);
    chk(rd, {16'h0, exp_val[2]});
    $display("instant test done");
    // Standalone manual load on group 1
    wait_clr(qdu_pkg::OFS_GSTAT, 32'h2);
    apb(1'b1, ctl(1), {29'h0, qdu_pkg::MODE_MANUAL});
    put(5);
    wait_clr(qdu_pkg::OFS_GSTAT, 32'h2);
    chk(outv(5), 32'h0);
    put(6);
    apb(1'b1, qdu_pkg::OFS_LOAD, 32'h2);
    apb(1'b0, qdu_pkg::OFS_GSTAT, 32'h0);
    chk(rd & 32'h2, 32'h2);
    wait_clr(qdu_pkg::OFS_LOAD, 32'h2);
    chk(rd & 32'h2, 32'h0);
    chk(outv(5), {16'h0, exp_val[5]});
    chk(outv(6), {16'h0, exp_val[6]});
    // Global load over groups 2 and 3, requested on group 2 only
    for (int g = 2; g < 4; g++) begin
      apb(1'b1, ctl(g), 32'(qdu_pkg::MODE_MANUAL) | (32'h1 << qdu_pkg::CTL_GLOB));
      put(4*g);
    end
    apb(1'b1, qdu_pkg::OFS_LOAD, 32'h4);
    wait_clr(qdu_pkg::OFS_LOAD, 32'hC);
    chk(outv(8), {16'h0, exp_val[8]});
    chk(outv(12), {16'h0, exp_val[12]});
    $display("manual test done");
    // Timed sequencing on groups 4 and 5, started by one write
    apb(1'b1, ctl(4), 32'(qdu_pkg::MODE_TIMED) | (32'h1 << qdu_pkg::CTL_SIE));
    apb(1'b1, ctl(5), 32'(qdu_pkg::MODE_TIMED));
    apb(1'b1, 8'(qdu_pkg::OFS_TMR0 + 16), 32'h14);
    apb(1'b1, 8'(qdu_pkg::OFS_TMR0 + 20), 32'h14);
    put(16);
    put(20);
    wait_clr(qdu_pkg::OFS_GSTAT, 32'h30);
    chk(outv(16), 32'h0);
    chk(outv(20), 32'h0);
    apb(1'b1, qdu_pkg::OFS_GCTRL, 32'h3001);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(negedge pclk);
    chk(outv(16), {16'h0, exp_val[16]});
    chk(outv(20), {16'h0, exp_val[20]});
    apb(1'b0, qdu_pkg::OFS_GSTAT, 32'h0);
    chk(rd & 32'h101010, 32'h001010);
    apb(1'b0, qdu_pkg::OFS_ISTAT, 32'h0);
    chk(rd, 32'h10);
    chk({31'h0, irq}, 32'h1);
    repeat (25) @(posedge pclk);
    apb(1'b0, qdu_pkg::OFS_GSTAT, 32'h0);
    chk(rd & 32'h100000, 32'h100000);
    apb(1'b1, qdu_pkg::OFS_GCTRL, 32'h1);
    wait_clr(qdu_pkg::OFS_GSTAT, 32'h30);
    chk(rd & 32'h30, 32'h0);
    apb(1'b1, qdu_pkg::OFS_GSTAT, 32'h303000);
    apb(1'b1, qdu_pkg::OFS_ISTAT, 32'h10);
    apb(1'b0, qdu_pkg::OFS_GSTAT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("timed test done");
    final_report();
  end
endmodule // quad_dac_update_mode_control_test
`default_nettype wire
